// ==== design/acr_pkg.sv ====
package acr_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ACR_OFS_INPUT_CONFIG = 8'h41;
   localparam logic [7:0] ACR_OFS_GAIN         = 8'h42;
   localparam logic [7:0] ACR_OFS_DIG_VOLUME   = 8'h43;
   localparam logic [7:0] ACR_OFS_GAIN_CAL     = 8'h44;

   // ==========================================================
   // Reset values
   localparam logic [7:0] ACR_RST_INPUT_CONFIG = 8'h00;
   localparam logic [7:0] ACR_RST_GAIN         = 8'h00;
   localparam logic [7:0] ACR_RST_DIG_VOLUME   = 8'hC9;
   localparam logic [7:0] ACR_RST_GAIN_CAL     = 8'h80;

   // ==========================================================
   // Field positions and masks
   localparam int         ACR_IMP_LSB       = 2;
   localparam int         ACR_AGC_EN_BIT    = 0;
   localparam int         ACR_POL_BIT       = 0;
   localparam int         ACR_LEVEL_LSB     = 1;
   localparam int         ACR_TRIM_LSB      = 4;
   localparam int         ACR_GLOBAL_AGC_BIT = 3;
   // Writable bits per register; zeros are reserved
   localparam logic [7:0] ACR_MASK_INPUT_CONFIG = 8'hFD;
   localparam logic [7:0] ACR_MASK_GAIN_CAL     = 8'hF0;

   // ==========================================================
   // Field codes
   localparam logic [1:0] ACR_IMP_2K5      = 2'h0;
   localparam logic [1:0] ACR_IMP_RESERVED = 2'h3;
   localparam logic [6:0] ACR_LEVEL_MAX    = 7'h54;
   localparam logic [7:0] ACR_NEG_FLOOR    = 8'h16;
   localparam logic [8:0] ACR_VOL_ZERO_DB  = 9'h0C9;
   localparam logic [4:0] ACR_TRIM_ZERO_DB = 5'h08;
   localparam logic [7:0] ACR_VOL_MUTE     = 8'h00;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } acr_req_t;

   typedef struct packed {
      logic [1:0]        impedance;
      logic              auto_level_active;
      logic signed [7:0] analog_half_db;
      logic              digital_mute;
      logic signed [8:0] digital_half_db;
      logic signed [4:0] trim_tenth_db;
      logic              setting_fault;
   } acr_cfg_t;

endpackage

// ==== design/acr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// (R1) Bits 3:2 at 0x41 select 2.5, 10 or 20 kilohm input; code 3 reserved.
// (R2) Bit 1 at 0x41 is reserved, reads zero; host writes zero only.
// (R3) Bit 0 at 0x41 enables channel AGC, qualified by bit 3 of register 108.
// (R4) Bits 7:1 at 0x42 give gain, 0.5 dB steps, 0 to 42 dB.
// (R5) Host must not program gain codes 85 to 127.
// (R6) Bit 0 at 0x42 sets gain sign; negative gain floors at -11 dB.
// (R7) Host sets negative sign only with 10 or 20 kilohm impedance.
// (R8) Register 0x43 is 8-bit digital volume; code zero mutes output.
// (R9) Volume codes step 0.5 dB: 1 is -100, 201 is 0, 255 is +27.
// (R10) Bits 7:4 at 0x44 trim gain 0.1 dB per step, 8 is 0 dB.
// (R11) Bits 3:0 at 0x44 are reserved, read zero; host writes zeros.
// (R12) Register 0x41 holds impedance, reserved bit, AGC enable; resets zero.
// (R13) Writes to reserved bits never change them; they always read zero.
module acr_regs
   import acr_pkg::*;
(
   input  wire logic       clk,             // Control clock
   input  wire logic       rst,             // Async reset, active high
   input  wire acr_req_t   req,             // Register access, same clock
   input  wire logic [7:0] auto_level_settings_reg, // Register 108 value
   output var  logic [7:0] rdata,           // Read data, one cycle later
   output var  logic       rvalid,          // Read data valid pulse
   output var  acr_cfg_t   cfg              // Decoded channel settings
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0] channel2_input_config;
      logic [7:0] channel2_gain;
      logic [7:0] channel2_digital_volume;
      logic [7:0] channel2_gain_calibration;
      logic [7:0] rdata;
      logic       rvalid;
      acr_cfg_t   cfg;
   } acr_state_t;

   acr_state_t st_r;
   acr_state_t st_nxt;

   logic [1:0]        imp_sel;
   logic [6:0]        level_code;
   logic              polarity;
   logic [7:0]        level_mag;
   logic [7:0]        vol_code;

   always_comb begin
      st_nxt        = st_r;
      st_nxt.rvalid = 1'b0;

      // ==========================================================
      // Writes; reserved positions masked off
      if (req.wr) begin
         if (req.addr == ACR_OFS_INPUT_CONFIG) begin
            st_nxt.channel2_input_config =
               req.wdata & ACR_MASK_INPUT_CONFIG; // R2 R12 R13
         end else if (req.addr == ACR_OFS_GAIN) begin
            st_nxt.channel2_gain = req.wdata; // R4 R6
         end else if (req.addr == ACR_OFS_DIG_VOLUME) begin
            st_nxt.channel2_digital_volume = req.wdata; // R8
         end else if (req.addr == ACR_OFS_GAIN_CAL) begin
            st_nxt.channel2_gain_calibration =
               req.wdata & ACR_MASK_GAIN_CAL; // R11 R13
         end
      end

      // ==========================================================
      // Reads; unmapped offsets return zero
      if (req.rd) begin
         st_nxt.rvalid = 1'b1;
         if (req.addr == ACR_OFS_INPUT_CONFIG) begin
            st_nxt.rdata = st_r.channel2_input_config; // R2
         end else if (req.addr == ACR_OFS_GAIN) begin
            st_nxt.rdata = st_r.channel2_gain;
         end else if (req.addr == ACR_OFS_DIG_VOLUME) begin
            st_nxt.rdata = st_r.channel2_digital_volume;
         end else if (req.addr == ACR_OFS_GAIN_CAL) begin
            st_nxt.rdata = st_r.channel2_gain_calibration; // R11
         end else begin
            st_nxt.rdata = 8'h00;
         end
      end

      // ==========================================================
      // Decode from the updated register copy so settings follow
      // a write by one cycle
      imp_sel    = st_nxt.channel2_input_config[ACR_IMP_LSB +: 2];
      level_code = st_nxt.channel2_gain[ACR_LEVEL_LSB +: 7];
      polarity   = st_nxt.channel2_gain[ACR_POL_BIT];
      vol_code   = st_nxt.channel2_digital_volume;

      st_nxt.cfg.impedance = imp_sel; // R1
      st_nxt.cfg.auto_level_active =
         st_nxt.channel2_input_config[ACR_AGC_EN_BIT] &
         auto_level_settings_reg[ACR_GLOBAL_AGC_BIT]; // R3

      level_mag = {1'b0, level_code};
      if (polarity) begin
         // Negative side cannot go below -11 dB
         if (level_mag > ACR_NEG_FLOOR) begin
            level_mag = ACR_NEG_FLOOR; // R6
         end
         st_nxt.cfg.analog_half_db = -$signed(level_mag); // R6
      end else begin
         st_nxt.cfg.analog_half_db = $signed(level_mag); // R4
      end

      st_nxt.cfg.digital_mute = (vol_code == ACR_VOL_MUTE); // R8
      st_nxt.cfg.digital_half_db =
         $signed({1'b0, vol_code} - ACR_VOL_ZERO_DB); // R9
      st_nxt.cfg.trim_tenth_db = $signed(
         {1'b0, st_nxt.channel2_gain_calibration[ACR_TRIM_LSB +: 4]}
         - ACR_TRIM_ZERO_DB); // R10

      // Host misuse is only flagged; the codes are still passed on
      st_nxt.cfg.setting_fault =
         (level_code > ACR_LEVEL_MAX) | // R5
         (polarity & (imp_sel == ACR_IMP_2K5)) | // R7
         (imp_sel == ACR_IMP_RESERVED); // R1
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r                           <= '0;
         st_r.channel2_input_config     <= ACR_RST_INPUT_CONFIG; // R12
         st_r.channel2_gain             <= ACR_RST_GAIN;
         st_r.channel2_digital_volume   <= ACR_RST_DIG_VOLUME;
         st_r.channel2_gain_calibration <= ACR_RST_GAIN_CAL;
         st_r.cfg.digital_mute          <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rdata  = st_r.rdata;
   assign rvalid = st_r.rvalid;
   assign cfg    = st_r.cfg;

endmodule

`default_nettype wire

// ==== sim/acr_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module acr_host
   import acr_pkg::*;
(
   input  wire logic     clk, // Control clock
   output var  acr_req_t req  // Register access
);
   initial req = '0;
   // Request set after an edge and held until the next call
   task automatic op(input logic w, r, input logic [7:0] a, d);
      @(posedge clk);
      req <= '{w, r, a, d};
   endtask
endmodule
`default_nettype wire

// ==== sim/acr_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module acr_chk
   import acr_pkg::*;
(
   input wire logic       clk,                     // Clock
   input wire logic       rst,                     // Reset
   input wire acr_req_t   req,                     // Request
   input wire logic [7:0] auto_level_settings_reg, // Reg 108
   input wire logic [7:0] rdata,                   // Read data
   input wire logic       rvalid,                  // Read valid
   input wire acr_cfg_t   cfg                      // Settings
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wr(a); req.wr && req.addr == a; endsequence
   sequence s_rd(a); req.rd && req.addr == a ##1 rvalid; endsequence
   a_read_answer: assert property (req.rd |=> rvalid) else $error("no answer");
   a_no_stray: assert property (!req.rd |=> !rvalid) else $error("stray valid");
   a_rsvd_bit: assert property (s_rd(8'h41) |-> !rdata[1])
      else $error("bit 1 set");
   a_cal_low: assert property (s_rd(8'h44) |-> rdata[3:0] == 4'h0)
      else $error("low bits set");
   a_imp_field: assert property (s_wr(8'h41) |=>
      cfg.impedance == $past(req.wdata[3:2])) else $error("impedance");
   a_agc_off: assert property (s_wr(8'h41) ##0 !req.wdata[0] |=>
      !cfg.auto_level_active) else $error("agc on");
   a_gain_pos: assert property (s_wr(8'h42) ##0 !req.wdata[0] |=>
      cfg.analog_half_db == {1'b0, $past(req.wdata[7:1])}) else $error("gain");
   a_neg_floor: assert property (cfg.analog_half_db >= -8'sd22)
      else $error("below floor");
   a_mute_code: assert property (s_wr(8'h43) |=>
      cfg.digital_mute == ($past(req.wdata) == 8'h00)) else $error("mute");
   a_vol_step: assert property (s_wr(8'h43) |=> cfg.digital_half_db ==
      $signed({1'b0, $past(req.wdata)}) - 9'sd201) else $error("volume");
   a_trim_step: assert property (s_wr(8'h44) |=> cfg.trim_tenth_db ==
      $signed({1'b0, $past(req.wdata[7:4])}) - 5'sd8) else $error("trim");
endmodule
bind acr_regs acr_chk u_chk (.clk(clk), .rst(rst), .req(req),
   .auto_level_settings_reg(auto_level_settings_reg), .rdata(rdata),
   .rvalid(rvalid), .cfg(cfg));
`default_nettype wire

// ==== sim/acr_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module acr_regs_tb;
   import acr_pkg::*;
   logic clk = 0, rst = 1, rvalid;
   logic [7:0] lvl = '0, rdata, mem [4], exp_q [$];
   logic [31:0] seed = 32'h645E6136;
   int mismatches = 0, samples_checked = 0, cyc = 0;
   acr_req_t req;
   acr_cfg_t cfg;
   always #50 clk = ~clk;
   acr_host host (.clk(clk), .req(req));
   acr_regs uut (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
      .auto_level_settings_reg(lvl), .rvalid(rvalid), .cfg(cfg));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input string n, input logic [8:0] e, s);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_of_test();
      $display("mismatches %0d samples_checked %0d", mismatches,
         samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // =====
   // Model: same-edge read sees the old value
   task automatic acc(input logic w, r, input logic [7:0] a, d);
      logic ok;
      ok = a >= 8'h41 && a <= 8'h44;
      if (r) exp_q.push_back(ok ? mem[a - 8'h41] : 8'h00);
      if (w && ok) mem[a - 8'h41] = d & (a == 8'h41 ? ACR_MASK_INPUT_CONFIG :
         a == 8'h44 ? ACR_MASK_GAIN_CAL : 8'hFF);
      host.op(w, r, a, d);
   endtask
   always @(negedge clk) if (rvalid === 1'b1)
      chk("rdata", exp_q.pop_front(), rdata);
   always @(posedge clk) begin
      lvl <= {lvl[6:0], ~lvl[7]};
      cyc++;
      if (cyc == 1000) begin
         mismatches++;
         end_of_test();
      end
   end
   initial begin
      logic [7:0] a, d;
      mem = '{8'h00, 8'h00, 8'hC9, 8'h80};
      repeat (6) @(posedge clk);
      rst <= 0;
      for (int i = 0; i < 6; i++) acc(0, 1, 8'(8'h40 + i), 0);
      repeat (60) begin
         a = 8'(32'h40 + rnd() % 6);
         d = 8'(rnd());
         if (a == 8'h42) d[7:1] = d[7:1] % 85;
         if (a == 8'h42 && mem[0][3:2] == 2'h0) d[0] = 0;
         if (a == 8'h41 && mem[1][0]) d[2] = 1'b1;
         if (a == 8'h41) d[1] = 1'b0;
         if (a == 8'h44) d[3:0] = 4'h0;
         acc(1, 1'(rnd()), a, d);
         acc(0, 1, a, 0);
      end
      acc(1, 0, 8'h41, 8'h04);
      acc(1, 0, 8'h42, 8'hA9);
      acc(1, 0, 8'h43, 8'h00);
      acc(0, 0, 0, 0);
      @(negedge clk);
      chk("floor", 9'h1EA, cfg.analog_half_db);
      chk("mute", 9'h001, cfg.digital_mute);
      chk("imp", 9'h001, cfg.impedance);
      chk("agc", 9'h000, cfg.auto_level_active);
      chk("volume", 9'h137, cfg.digital_half_db);
      chk("fault", 9'h000, cfg.setting_fault);
      repeat (3) @(posedge clk);
      end_of_test();
   end
endmodule
`default_nettype wire
